// ===== bcmr_pkg.sv
// constants and types for the board configuration mailbox register bank
// Summary of operation
// - A read-only identity word carries an implementer code in bits 31:24 and the design number in bits 15:4.
// - Identity bits 23:20 give the major revision (x of rxpy) of the processor image.
// - Identity bits 3:0 give the minor revision (y of rxpy) of the processor image.
// - The mailbox carries software read and write requests to board peripherals, the controller doing the transfer.
// - The return data word is read-only to software; software writes leave it unchanged.
// - Software stages the 32-bit outbound value, and the device hands it on toward the addressed component.
// - A software write to the control word clears the error and complete status flags, except a flag that the controller reports in that same cycle.
// - A software write with the start bit (bit 31) set raises an interrupt toward the controller.
// - Control holds direction at bit 30, function at bits 25:20 and device select at bits 11:0.
package bcmr_pkg;

    // software register port word indices
    localparam logic [2:0] IDX_DESIGN_IDENTITY = 3'h0;
    localparam logic [2:0] IDX_RETURN_DATA = 3'h1;
    localparam logic [2:0] IDX_OUTGOING_DATA = 3'h2;
    localparam logic [2:0] IDX_TRANSFER_CONTROL = 3'h3;
    localparam logic [2:0] IDX_TRANSFER_STATUS = 3'h4;

    // identity field positions
    localparam int ID_IMPL_LSB = 24;
    localparam int ID_MAJOR_LSB = 20;
    localparam int ID_ARCH_LSB = 16;
    localparam int ID_DESIGN_LSB = 4;
    localparam int ID_MINOR_LSB = 0;

    // control field positions
    localparam int CTRL_START_BIT = 31;
    localparam int CTRL_DIR_BIT = 30;
    localparam int CTRL_FUNC_LSB = 20;
    localparam int CTRL_DEV_LSB = 0;

    // status field positions
    localparam int STAT_ERROR_BIT = 1;
    localparam int STAT_COMPLETE_BIT = 0;

    // function and device codes
    localparam logic [5:0] FUNC_CLOCK_GEN = 6'h01;
    localparam logic [11:0] DEV_CLOCK_GEN_LAST = 12'h002;

    // values after reset
    localparam logic [31:0] DATA_RESET = 32'h0000_0000;
    localparam logic [5:0] FUNC_RESET = 6'h00;
    localparam logic [11:0] DEV_RESET = 12'h000;

    typedef struct packed {
        logic start;
        logic transfer_direction; // 0 read, 1 write
        logic [5:0] func;
        logic [11:0] device;
    } bcmr_ctrl_type;

    typedef struct packed {
        logic error;
        logic complete;
    } bcmr_stat_type;

    localparam bcmr_ctrl_type CTRL_RESET = '{1'b0, 1'b0, FUNC_RESET, DEV_RESET};
    localparam bcmr_stat_type STAT_RESET = '{1'b0, 1'b0};

endpackage

// ===== bcmr_regs.sv
// design identity and board configuration mailbox registers
`timescale 1ns/10ps
`default_nettype none
module bcmr_regs
    import bcmr_pkg::*;
#(
    parameter logic [7:0] IMPLEMENTER_CODE = 8'h5a, // arbitrary value
    parameter logic [3:0] MAJOR_REVISION = 4'h0,
    parameter logic [3:0] ARCH_CODE = 4'h4,
    parameter logic [11:0] DESIGN_NUMBER = 12'h001, // arbitrary value
    parameter logic [3:0] MINOR_REVISION = 4'h0
) (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_clk_en,
    // software register port
    input wire logic i_sw_sel,
    input wire logic i_sw_write,
    input wire logic [2:0] i_sw_index,
    input wire logic [31:0] i_sw_wdata,
    output logic [31:0] o_sw_rdata,
    // management controller side
    input wire logic i_mc_rtn_we,
    input wire logic [31:0] i_mc_rtn_data,
    input wire logic i_mc_done,
    input wire logic i_mc_fail,
    output logic o_mc_start_irq,
    output bcmr_ctrl_type o_mc_ctrl,
    output logic [31:0] o_mc_out_data,
    output logic [31:0] o_mc_identity
);

    // identity word is fixed, only the controller and software read it
    function automatic logic [31:0] identity_word();
        logic [31:0] w;
        w = 32'h0000_0000;
        w[ID_IMPL_LSB +: 8] = IMPLEMENTER_CODE;
        w[ID_MAJOR_LSB +: 4] = MAJOR_REVISION;
        w[ID_ARCH_LSB +: 4] = ARCH_CODE;
        w[ID_DESIGN_LSB +: 12] = DESIGN_NUMBER;
        w[ID_MINOR_LSB +: 4] = MINOR_REVISION;
        return w;
    endfunction

    // control struct packed into its register word, reserved bits zero
    function automatic logic [31:0] ctrl_word(input bcmr_ctrl_type c);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[CTRL_START_BIT] = c.start;
        w[CTRL_DIR_BIT] = c.transfer_direction;
        w[CTRL_FUNC_LSB +: 6] = c.func;
        w[CTRL_DEV_LSB +: 12] = c.device;
        return w;
    endfunction

    // status flags packed into their register word, reserved bits zero
    function automatic logic [31:0] stat_word(input bcmr_stat_type s);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[STAT_ERROR_BIT] = s.error;
        w[STAT_COMPLETE_BIT] = s.complete;
        return w;
    endfunction

    // a software write aimed at one word index
    function automatic logic sw_write_hit(
        input logic sel,
        input logic write,
        input logic [2:0] index,
        input logic [2:0] target
    );
        return sel && write && (index == target);
    endfunction

    logic [31:0] rtn_q, rtn_d;
    logic [31:0] out_q, out_d;
    bcmr_ctrl_type ctrl_q, ctrl_d;
    bcmr_stat_type stat_q, stat_d;
    logic irq_q, irq_d;
    logic [31:0] rdata_q, rdata_d;
    logic [31:0] ident_q, ident_d;
    logic wr_out;
    logic wr_ctrl;

    // write strobes; indices 0, 1 and 4 have none, so writes there fall away
    assign wr_out = sw_write_hit(i_sw_sel, i_sw_write, i_sw_index, IDX_OUTGOING_DATA);
    assign wr_ctrl = sw_write_hit(i_sw_sel, i_sw_write, i_sw_index, IDX_TRANSFER_CONTROL);

    // return data: only the controller loads it, software has no path in
    always_comb begin
        rtn_d = rtn_q;
        if (i_mc_rtn_we) begin
            rtn_d = i_mc_rtn_data;
        end
    end

    // return data register, frozen while the clock enable is low
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rtn_q <= DATA_RESET;
        end else if (i_clk_en) begin
            rtn_q <= rtn_d;
        end
    end

    // outgoing data: software stages it before a write transfer
    always_comb begin
        out_d = out_q;
        if (wr_out) begin
            out_d = i_sw_wdata;
        end
    end

    // outgoing data register
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            out_q <= DATA_RESET;
        end else if (i_clk_en) begin
            out_q <= out_d;
        end
    end

    // control fields; start is kept and reads back as last written
    always_comb begin
        ctrl_d = ctrl_q;
        if (wr_ctrl) begin
            ctrl_d.start = i_sw_wdata[CTRL_START_BIT];
            ctrl_d.transfer_direction = i_sw_wdata[CTRL_DIR_BIT];
            ctrl_d.func = i_sw_wdata[CTRL_FUNC_LSB +: 6];
            ctrl_d.device = i_sw_wdata[CTRL_DEV_LSB +: 12];
        end
    end

    // control register
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ctrl_q <= CTRL_RESET;
        end else if (i_clk_en) begin
            ctrl_q <= ctrl_d;
        end
    end

    // start request: one pulse per control write with start set; it stretches while disabled
    always_comb begin
        irq_d = 1'b0;
        if (wr_ctrl) begin
            irq_d = i_sw_wdata[CTRL_START_BIT];
        end
    end

    // start request register
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            irq_q <= 1'b0;
        end else if (i_clk_en) begin
            irq_q <= irq_d;
        end
    end

    // status flags: a control write clears them, but a report in that same cycle still lands
    always_comb begin
        stat_d = stat_q;
        if (wr_ctrl) begin
            stat_d = STAT_RESET;
        end
        if (i_mc_fail) begin
            stat_d.error = 1'b1;
        end
        if (i_mc_done) begin
            stat_d.complete = 1'b1;
        end
    end

    // status register
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            stat_q <= STAT_RESET;
        end else if (i_clk_en) begin
            stat_q <= stat_d;
        end
    end

    // read data is registered, so it appears one cycle after the select
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (i_sw_sel && !i_sw_write) begin
            if (i_sw_index == IDX_DESIGN_IDENTITY) begin
                rdata_d = identity_word();
            end else if (i_sw_index == IDX_RETURN_DATA) begin
                rdata_d = rtn_q;
            end else if (i_sw_index == IDX_OUTGOING_DATA) begin
                rdata_d = out_q;
            end else if (i_sw_index == IDX_TRANSFER_CONTROL) begin
                rdata_d = ctrl_word(ctrl_q);
            end else if (i_sw_index == IDX_TRANSFER_STATUS) begin
                rdata_d = stat_word(stat_q);
            end
        end
    end

    // read data register; it falls back to zero so a stale word never lingers
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rdata_q <= DATA_RESET;
        end else if (i_clk_en) begin
            rdata_q <= rdata_d;
        end
    end

    // identity word, fixed by the build parameters
    assign ident_d = identity_word();

    // identity output held in a flop so every output is registered
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ident_q <= DATA_RESET;
        end else if (i_clk_en) begin
            ident_q <= ident_d;
        end
    end

    // outputs, each straight from its flop
    assign o_sw_rdata = rdata_q;
    assign o_mc_start_irq = irq_q;
    assign o_mc_ctrl = ctrl_q;
    assign o_mc_out_data = out_q;
    assign o_mc_identity = ident_q;

endmodule
`default_nettype wire

// ===== bcmr_regs_sva.sv
// assertion checker for the mailbox register bank
`timescale 1ns/10ps
`default_nettype none
module bcmr_regs_sva
    import bcmr_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_clk_en,
    input wire logic i_sw_sel,
    input wire logic i_sw_write,
    input wire logic [2:0] i_sw_index,
    input wire logic [31:0] i_sw_wdata,
    input wire logic [31:0] o_sw_rdata,
    input wire logic i_mc_rtn_we,
    input wire logic [31:0] i_mc_rtn_data,
    input wire logic i_mc_done,
    input wire logic i_mc_fail,
    input wire logic o_mc_start_irq,
    input wire bcmr_ctrl_type o_mc_ctrl,
    input wire logic [31:0] o_mc_out_data
);
    // decoded accesses; a disabled clock takes nothing
    wire rd = i_clk_en && i_sw_sel && !i_sw_write;
    wire wr = i_clk_en && i_sw_sel && i_sw_write;
    wire cw = wr && i_sw_index == IDX_TRANSFER_CONTROL;
    wire sr = rd && i_sw_index == IDX_TRANSFER_STATUS;
    wire quiet = !i_mc_done && !i_mc_fail;
    // last word the controller loaded; software writes must never reach it
    logic [31:0] rtn_seen;
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rtn_seen <= DATA_RESET;
        end else if (i_clk_en && i_mc_rtn_we) begin
            rtn_seen <= i_mc_rtn_data;
        end
    end
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);
    a_irq_start: assert property (cw && i_sw_wdata[31] |=> o_mc_start_irq) else $error("no start irq");
    a_irq_cause: assert property ($rose(o_mc_start_irq) |-> $past(cw) && $past(i_sw_wdata[31]))
        else $error("stray irq");
    a_ctrl_load: assert property (cw |=> o_mc_ctrl == {$past(i_sw_wdata[31:30]), $past(i_sw_wdata[25:20]),
        $past(i_sw_wdata[11:0])}) else $error("control fields");
    a_out_load: assert property (wr && i_sw_index == IDX_OUTGOING_DATA |=> o_mc_out_data == $past(i_sw_wdata))
        else $error("outgoing data");
    a_stat_clear: assert property (cw && quiet ##1 quiet ##1 sr |=> o_sw_rdata == 32'h0) else $error("status kept");
    a_done_seen: assert property (i_clk_en && i_mc_done ##1 sr |=> o_sw_rdata[STAT_COMPLETE_BIT])
        else $error("done lost");
    a_rtn_read: assert property (rd && i_sw_index == IDX_RETURN_DATA |=> o_sw_rdata == $past(rtn_seen))
        else $error("return data");
    a_rdata_idle: assert property (i_clk_en && !rd |=> o_sw_rdata == 32'h0) else $error("read data held");
    c_write: cover property (cw && i_sw_wdata[30]);
    c_read: cover property (i_mc_rtn_we);
    c_fail: cover property (i_mc_fail);
endmodule
bind bcmr_regs bcmr_regs_sva i_sva (.*);
`default_nettype wire

// ===== bcmr_mc_model.sv
// behavioural board management controller answering mailbox requests
`timescale 1ns/10ps
`default_nettype none
module bcmr_mc_model
    import bcmr_pkg::*;
#(
    parameter logic [31:0] RTN_BASE = 32'h0000_1000
) (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_irq,
    input wire bcmr_ctrl_type i_ctrl,
    input wire logic i_slow,
    input wire logic i_fail_req,
    output logic o_rtn_we,
    output logic [31:0] o_rtn_data,
    output logic o_done,
    output logic o_fail
);
    logic [2:0] cnt_q;
    // answer one or four cycles after the irq; idle data toggles so a stale word never looks valid
    always @(posedge i_clk_sys or negedge i_reset_n) begin
        o_rtn_we <= 1'b0;
        o_done <= 1'b0;
        o_fail <= 1'b0;
        o_rtn_data <= ~o_rtn_data;
        cnt_q <= (cnt_q == 3'h0) ? cnt_q : cnt_q - 3'h1;
        if (!i_reset_n) begin
            cnt_q <= 3'h0;
            o_rtn_data <= 32'h0;
        end else if (i_irq) begin
            cnt_q <= i_slow ? 3'h4 : 3'h1;
        end else if (cnt_q == 3'h1) begin
            o_fail <= i_fail_req;
            o_done <= !i_fail_req;
            o_rtn_we <= !i_ctrl.transfer_direction;
            o_rtn_data <= RTN_BASE + 32'(i_ctrl.device);
        end
    end
endmodule
`default_nettype wire

// ===== testbench.sv
// self-checking bench for the mailbox register bank
`timescale 1ns/10ps
`default_nettype none
module testbench import bcmr_pkg::*;;
    localparam logic [31:0] RTN = 32'h016e_3600;
    localparam logic [31:0] ID = 32'h5a34_0017;
    logic i_clk_sys = 1'b0;
    logic i_reset_n = 1'b1;
    logic i_clk_en = 1'b1;
    logic i_sw_sel = 1'b0;
    logic i_sw_write = 1'b0;
    logic [2:0] i_sw_index = 3'h0;
    logic [31:0] i_sw_wdata = 32'h0;
    logic i_mc_rtn_we, i_mc_done, i_mc_fail, o_mc_start_irq;
    logic [31:0] i_mc_rtn_data, o_sw_rdata, o_mc_out_data, o_mc_identity;
    bcmr_ctrl_type o_mc_ctrl;
    logic slow = 1'b0;
    logic fail_req = 1'b0;
    int n_mismatch = 0;
    int n_checks = 0;
    int d;
    // 40 MHz clock
    always #12.5 i_clk_sys = ~i_clk_sys;
    // nonzero revisions so a field in the wrong place shows up
    bcmr_regs #(.MAJOR_REVISION(4'h3), .MINOR_REVISION(4'h7)) i_bcmr_regs (.i_clk_sys, .i_reset_n, .i_clk_en,
        .i_sw_sel, .i_sw_write, .i_sw_index, .i_sw_wdata,
        .o_sw_rdata, .i_mc_rtn_we, .i_mc_rtn_data, .i_mc_done, .i_mc_fail, .o_mc_start_irq, .o_mc_ctrl,
        .o_mc_out_data, .o_mc_identity);
    bcmr_mc_model #(.RTN_BASE(RTN)) i_bcmr_mc_model (.i_clk_sys, .i_reset_n, .i_irq(o_mc_start_irq),
        .i_ctrl(o_mc_ctrl), .i_slow(slow), .i_fail_req(fail_req), .o_rtn_we(i_mc_rtn_we),
        .o_rtn_data(i_mc_rtn_data), .o_done(i_mc_done), .o_fail(i_mc_fail));
    task chk(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, s, e);
        end
    endtask
    // one access; returns just after the take edge, where read data stands
    task acc(input logic w, input logic [2:0] x, input logic [31:0] v);
        @(posedge i_clk_sys);
        i_sw_sel <= 1'b1;
        i_sw_write <= w;
        i_sw_index <= x;
        i_sw_wdata <= v;
        @(posedge i_clk_sys);
        i_sw_sel <= 1'b0;
        #1;
    endtask
    task rd(input logic [2:0] x, input logic [31:0] e);
        acc(1'b0, x, 32'h0);
        chk(o_sw_rdata, e);
    endtask
    // bounded status poll; an exhausted poll shows up as a mismatch
    task pw(input logic [31:0] e);
        int k;
        k = 0;
        do begin
            acc(1'b0, IDX_TRANSFER_STATUS, 32'h0);
            k++;
        end while (o_sw_rdata === 32'h0 && k < 9);
        if (o_sw_rdata === 32'h0) begin
            n_mismatch++; // poll ran out: close the run
            test_done();
        end else begin
            chk(o_sw_rdata, e);
        end
    endtask
    task test_done;
        if (n_mismatch == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // main sequence
    initial begin
        i_reset_n = 1'b0;
        repeat (3) @(posedge i_clk_sys);
        i_reset_n <= 1'b1;
        rd(IDX_DESIGN_IDENTITY, ID);
        chk(o_mc_identity, ID);
        acc(1'b1, IDX_DESIGN_IDENTITY, 32'h0);
        rd(IDX_DESIGN_IDENTITY, ID);
        acc(1'b1, IDX_OUTGOING_DATA, RTN);
        chk(o_mc_out_data, RTN);
        // a write while the clock enable is low must leave the staged word alone
        @(posedge i_clk_sys);
        i_clk_en <= 1'b0;
        acc(1'b1, IDX_OUTGOING_DATA, 32'h0);
        @(posedge i_clk_sys);
        i_clk_en <= 1'b1;
        chk(o_mc_out_data, RTN);
        acc(1'b1, IDX_TRANSFER_CONTROL, 32'hc010_0001);
        chk({12'h0, o_mc_ctrl}, 32'h000c_1001);
        pw(32'h1);
        acc(1'b1, IDX_TRANSFER_CONTROL, 32'h0010_0001);
        rd(IDX_TRANSFER_STATUS, 32'h0);
        slow = 1'b1;
        for (d = 0; d < 3; d++) begin
            acc(1'b1, IDX_TRANSFER_CONTROL, 32'h8010_0000 | d);
            pw(32'h1);
            rd(IDX_RETURN_DATA, RTN + d);
            acc(1'b1, IDX_RETURN_DATA, 32'hffff_ffff);
            rd(IDX_RETURN_DATA, RTN + d);
        end
        fail_req = 1'b1;
        acc(1'b1, IDX_TRANSFER_CONTROL, 32'hc010_0002);
        pw(32'h2);
        acc(1'b1, IDX_TRANSFER_CONTROL, 32'h0);
        rd(IDX_TRANSFER_STATUS, 32'h0);
        rd(3'h5, 32'h0);
        test_done();
    end
endmodule
`default_nettype wire
